/* File: test/five_channel_pwm_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defines.vh"
module five_channel_pwm_timer_tb;
  // ------------------------------------------------------------
  // stimulus, model state and checks
  // ------------------------------------------------------------
  logic        clock = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, ext_clk = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0, d;
  wire  [31:0] rd_data;
  wire  [3:0]  pins;
  wire  [4:0]  irq;
  integer      num_errors = 0, checked = 0, cyc = 0, n4 = 0, t, i, s, r2, last;
  integer      rld[0:4], pre[0:1], gaps[$];
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (irq[4] === 1'b1) n4 <= n4 + 1;
  end
  five_channel_pwm_timer u_five_channel_pwm_timer (
    .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .external_timer_clock(ext_clk),
    .timer_output_pin(pins), .irq_pulse(irq));
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] seen);
    checked = checked + 1;
    if (seen !== e) begin
      num_errors = num_errors + 1;
      $display("unexpected %s: expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    wr_stb  <= 1'b1;
    addr    <= a;
    wr_data <= v;
    @(posedge clock);
    wr_stb  <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk(what, e, rd_data);
  endtask
  task automatic wait_irq(input integer n);
    integer k;
    k = 0;
    do begin
      @(posedge clock);
      k = k + 1;
    end while (irq[n] !== 1'b1 && k < 4000);
    if (k >= 4000) begin
      chk("irq wait", 32'h1, 32'h0);
      summarize();
    end
  endtask
  // each rising edge of the external clock is one tick of a timer selecting it
  task automatic ext_edges(input integer k);
    repeat (k) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  initial begin
    i = $urandom(26);
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) rdchk(8'(4 * i), 32'h0, "reset value");
    rdchk(8'h60, 32'h0, "unmapped");
    d = $urandom & 32'hFF00_0303;
    pre[0] = d[7:0];
    pre[1] = d[15:8];
    wr(`A_PRESCALER, d);
    rdchk(`A_PRESCALER, d & 32'h00FF_FFFF, "prescaler");
    wr(`A_DIVSEL, ($urandom & 32'hFFF0_0000) | 32'h0004_3210);
    rdchk(`A_DIVSEL, 32'h0004_3210, "divider select");
    wr(`A_IRQ_EN, 32'hFFFF_FFFF);
    rdchk(`A_IRQ_EN, 32'h0000_001F, "irq enable");
    for (t = 0; t < 5; t++) begin
      rld[t] = 4 + $urandom % 4;
      wr(8'(16 * t + 16), ($urandom & 32'hFFFF_0000) | rld[t]);
      wr(8'(16 * t + 20), 32'h1);
      rdchk(8'(16 * t + 16), rld[t], "reload buffer");
    end
    // timer t uses divider 2 << t and prescaler t / 2
    for (t = 0; t < 4; t++) begin
      s = (pre[t / 2] + 1) * (2 << t);
      wr(`A_CONTROL, 32'hA << (4 * t));
      rdchk(8'(16 * t + 24), rld[t], "observation");
      chk("pin low", 32'h0, pins[t]);
      wr(`A_CONTROL, 32'h9 << (4 * t));
      wait_irq(t);
      chk("pin high", 32'h1, pins[t]);
      last = cyc;
      r2 = 2 + $urandom % 4;
      wr(8'(16 * t + 16), r2);
      gaps.push_back((rld[t] + 1) * s);
      gaps.push_back((r2 + 1) * s);
      rld[t] = r2;
      repeat (2) begin
        wait_irq(t);
        chk("period", gaps.pop_front(), cyc - last);
        last = cyc;
      end
      wr(`A_CONTROL, 32'h0);
    end
    // stopped timer 0: compare just below, at and above the count
    for (i = 0; i < 6; i++) begin
      wr(`A_TIMER_BASE + 8'h04, rld[0] - 1 + i / 2);
      wr(`A_CONTROL, 32'h2 | ((i % 2) << 2));
      wr(`A_CONTROL, (i % 2) << 2);
      repeat (2) @(posedge clock);
      chk("pin level", (rld[0] <= rld[0] - 1 + i / 2) ^ (i % 2), pins[0]);
      wr(`A_CONTROL, ((i + 1) % 2) << 2);
      repeat (2) @(posedge clock);
      chk("pin inverted", (rld[0] > rld[0] - 1 + i / 2) ^ (i % 2), pins[0]);
    end
    // zero dead zone length: pin 1 carries the complement of timer 0
    wr(`A_CONTROL, 32'h0010_0000);
    repeat (3) @(posedge clock);
    chk("dead zone pin0", 32'h1, pins[0]);
    chk("dead zone pin1", 32'h0, pins[1]);
    wr(`A_CONTROL, 32'h0010_0004);
    repeat (3) @(posedge clock);
    chk("dead zone pin0", 32'h0, pins[0]);
    chk("dead zone pin1", 32'h1, pins[1]);
    wr(`A_CONTROL, 32'h2 << 16);
    wr(`A_CONTROL, 32'h1 << 16);
    ext_edges(2);
    rdchk(8'h58, rld[4] - 2, "external count");
    wr(`A_CONTROL, 32'h0);
    ext_edges(2);
    rdchk(8'h58, rld[4] - 2, "stopped count");
    wr(`A_CONTROL, 32'h1 << 16);
    ext_edges(rld[4] - 2);
    chk("one-shot requests", 32'h1, n4);
    ext_edges(3);
    chk("requests after zero", 32'h1, n4);
    rdchk(8'h58, 32'h0, "count at zero");
    summarize();
  end
endmodule // five_channel_pwm_timer_tb
`default_nettype wire

/* File: test/pwm_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defines.vh"
module pwm_timer_props (
  input wire logic               clock,            // bus clock
  input wire logic               nrst,             // async reset
  input wire logic [`ADDR_W-1:0] addr,             // byte address
  input wire logic [31:0]        wr_data,          // write data
  input wire logic               wr_stb,           // write strobe
  input wire logic               rd_stb,           // read strobe
  input wire logic [31:0]        rd_data,          // read data
  input wire logic [3:0]         timer_output_pin, // pwm levels
  input wire logic [4:0]         irq_pulse         // zero requests
);
  // ------------------------------------------------------------
  // shadow of what software wrote
  // ------------------------------------------------------------
  logic [4:0]  ien_q;
  logic [15:0] rld0_q;
  logic [20:0] ctl_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ien_q  <= 5'h00;
      rld0_q <= 16'h0000;
      ctl_q  <= 21'h000000;
    end else if (wr_stb) begin
      if (addr == `A_IRQ_EN) ien_q <= wr_data[4:0];
      if (addr == `A_TIMER_BASE) rld0_q <= wr_data[15:0];
      if (addr == `A_CONTROL) ctl_q <= wr_data[20:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence read_of(logic [7:0] a);
    rd_stb && addr == a;
  endsequence
  // of the timer 0 and dead-zone bits only the timer 0 inverter changes, timer stopped and settled
  sequence invert_only;
    wr_stb && addr == `A_CONTROL && $stable(ctl_q) && ctl_q[1:0] == 2'b00 && !ctl_q[20]
      && !wr_data[20] && (wr_data[3:0] ^ ctl_q[3:0]) == 4'h4;
  endsequence
  rd_idle_zero_a: assert property (!rd_stb |=> rd_data == 32'h0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (rd_stb && addr > `A_TIMER_LAST |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  ien_read_a: assert property (read_of(`A_IRQ_EN) |=> rd_data == {27'h0, $past(ien_q)})
    else $error("irq enable read wrong");
  reload_read_a: assert property (read_of(`A_TIMER_BASE) |=> rd_data == {16'h0, $past(rld0_q)})
    else $error("reload buffer read wrong");
  irq_masked_a: assert property ((irq_pulse & ~ien_q & ~$past(ien_q)) == 5'h00)
    else $error("request from masked timer");
  irq_single_a: assert property (|irq_pulse |=> (irq_pulse & $past(irq_pulse)) == 5'h00)
    else $error("request longer than one cycle");
  invert_now_a: assert property (invert_only |=> ##1 timer_output_pin[0] != $past(timer_output_pin[0], 2))
    else $error("inverter did not flip pin");
  one_shot_a: assert property (irq_pulse[4] && !ctl_q[19] && !$past(ctl_q[19], 2) |=> !irq_pulse[4] [*4])
    else $error("one-shot timer requested again");
endmodule // pwm_timer_props
bind five_channel_pwm_timer pwm_timer_props u_pwm_timer_props (
  .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .timer_output_pin(timer_output_pin), .irq_pulse(irq_pulse)
);
`default_nettype wire

/* File: verilog/five_channel_pwm_timer.v */
// Behaviour
// - five 16-bit down counters; timers 0-3 drive pins, timer 4 internal only.
// - timers 0,1 share 8-bit prescaler; timers 2,3,4 share a second one.
// - each timer picks divide by 2, 4, 8, 16 or external timer clock.
// - tick rate is clock over (prescaler plus one) over selected divider.
// - while manual update is set, buffers are copied into counter and compare latch.
// - at zero with auto-reload, reload counter and compare latch, keep counting.
// - at zero without auto-reload, timer stops with no further counts.
// - interrupt pulse each time counter reaches zero, when enabled for that timer.
// - uninverted output goes high once counter falls to compare latch value.
// - at zero, reload buffer captured into holding register, loaded next tick.
// - clearing start holds the counter value, no reload from buffer.
// - buffer writes during a period only take effect at next reload.
// - reading the reload buffer returns the stored value, not the counter.
// - read-only observation register per timer shows live counter value.
// - with dead zone off, inverter bit flips the output level at once, running or stopped.
// - after start, counting begins within one timer tick.
// - timer 0 has a dead-zone generator for a complementary output pair.
`include "pwm_timer_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module five_channel_pwm_timer #(
  parameter NUM_TIMERS = 5,                    // timer count
  parameter CNT_W      = 16                    // counter width
) (
  input  wire                clock,            // 125 MHz bus clock
  input  wire                nrst,             // async reset, active low
  input  wire [`ADDR_W-1:0]  addr,             // register byte address
  input  wire [31:0]         wr_data,          // write data
  input  wire                wr_stb,           // write strobe
  input  wire                rd_stb,           // read strobe
  output reg  [31:0]         rd_data,          // read data, cycle after rd_stb
  input  wire                external_timer_clock, // asynchronous tick source
  output reg  [3:0]          timer_output_pin, // pwm outputs of timers 0-3
  output reg  [4:0]          irq_pulse         // one-cycle zero-reached requests
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // divider hit on the prescaler pulse that ends a 2/4/8/16 group
  function div_hit;
    input [3:0] cnt;
    input [3:0] sel;
    begin
      case (sel)
        `SEL_DIV2:  div_hit = cnt[0];
        `SEL_DIV4:  div_hit = &cnt[1:0];
        `SEL_DIV8:  div_hit = &cnt[2:0];
        default:    div_hit = &cnt;
      endcase
    end
  endfunction

  // true when addr selects register sub inside the timer block starting at blk
  function reg_hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] blk;
    input [3:0]         sub;
    begin
      reg_hit = (a == blk + {4'h0, sub});
    end
  endfunction

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg  [23:0]           prescaler_config_q;
  reg  [`DIV_W-1:0]     divider_select_config_q;
  reg  [`CTL_W-1:0]     timer_control_bits_q;
  reg  [4:0]            irq_enable_q;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescaler_config_q      <= 24'h000000;
      divider_select_config_q <= 20'h00000;
      timer_control_bits_q    <= 21'h000000;
      irq_enable_q            <= 5'h00;
    end else if (wr_stb) begin
      if (addr == `A_PRESCALER) begin
        prescaler_config_q <= wr_data[23:0];
      end else if (addr == `A_DIVSEL) begin
        divider_select_config_q <= wr_data[`DIV_W-1:0];
      end else if (addr == `A_CONTROL) begin
        timer_control_bits_q <= wr_data[`CTL_W-1:0];
      end else if (addr == `A_IRQ_EN) begin
        irq_enable_q <= wr_data[4:0];
      end
    end
  end

  wire [`PRE_W-1:0] pre0_val = prescaler_config_q[`PRE0_LSB +: `PRE_W];
  wire [`PRE_W-1:0] pre1_val = prescaler_config_q[`PRE1_LSB +: `PRE_W];
  wire [`PRE_W-1:0] dz_len   = prescaler_config_q[`DZLEN_LSB +: `PRE_W];
  wire              dz_en    = timer_control_bits_q[`CTL_DZ_EN];

  // ----------------------------------------------------------------
  // prescalers
  // ----------------------------------------------------------------
  reg  [`PRE_W-1:0] pre0_cnt_q;
  reg  [`PRE_W-1:0] pre1_cnt_q;
  wire              pre0_tick = (pre0_cnt_q == pre0_val);
  wire              pre1_tick = (pre1_cnt_q == pre1_val);

  // a lowered value while the count is above it wraps through zero once
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre0_cnt_q <= 8'h00;
      pre1_cnt_q <= 8'h00;
    end else begin
      pre0_cnt_q <= pre0_tick ? 8'h00 : pre0_cnt_q + 8'h01;
      pre1_cnt_q <= pre1_tick ? 8'h00 : pre1_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // external clock synchroniser and edge detect
  // ----------------------------------------------------------------
  // jitter of up to one bus clock on each external edge is inherent
  reg ext_meta_q;
  reg ext_sync_q;
  reg ext_prev_q;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= external_timer_clock;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  wire ext_rise = ext_sync_q & ~ext_prev_q;

  // ----------------------------------------------------------------
  // timer channels
  // ----------------------------------------------------------------
  wire [CNT_W*NUM_TIMERS-1:0] reload_all;
  wire [CNT_W*NUM_TIMERS-1:0] compare_all;
  wire [CNT_W*NUM_TIMERS-1:0] counter_all;
  wire [NUM_TIMERS-1:0]       level_all;
  wire [NUM_TIMERS-1:0]       zero_all;
  wire [NUM_TIMERS-1:0]       tick_all;

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g = g + 1) begin : chan
      // genvar arithmetic is 32 bits wide; only the low address bits pick a block
      wire [31:0]        base_full = `A_TIMER_BASE + (g << `TIMER_IDX_LSB);
      wire [`ADDR_W-1:0] base      = base_full[`ADDR_W-1:0];
      wire [3:0]  sel    = divider_select_config_q[g*`DIV_STRIDE +: `DIV_STRIDE];
      wire        start  = timer_control_bits_q[g*`CTL_STRIDE + `CTL_START];
      wire        manual = timer_control_bits_q[g*`CTL_STRIDE + `CTL_MANUAL];
      wire        invert = timer_control_bits_q[g*`CTL_STRIDE + `CTL_INVERT];
      wire        auto   = timer_control_bits_q[g*`CTL_STRIDE + `CTL_AUTO];
      wire        pre_p  = (g < 2) ? pre0_tick : pre1_tick;

      reg  [3:0]       div_q;
      reg  [CNT_W-1:0] count_reload_buffer_q;
      reg  [CNT_W-1:0] compare_buffer_q;
      reg  [CNT_W-1:0] internal_down_counter_q;
      reg  [CNT_W-1:0] compare_latch_q;
      reg  [CNT_W-1:0] hold_cnt_q;
      reg  [CNT_W-1:0] hold_cmp_q;
      reg              hold_valid_q;
      reg              zero_q;

      wire tick = (sel >= `SEL_EXT) ? ext_rise : (pre_p & div_hit(div_q, sel));
      // manual update overrides counting, so it must not raise a request either
      wire reach_zero = start & ~manual & tick & (internal_down_counter_q == 16'h0001);

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          div_q <= 4'h0;
        end else if (pre_p) begin
          div_q <= div_q + 4'h1;
        end
      end

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          count_reload_buffer_q <= `RST_16;
          compare_buffer_q      <= `RST_16;
        end else if (wr_stb) begin
          if (reg_hit(addr, base, `SUB_RELOAD)) begin
            count_reload_buffer_q <= wr_data[CNT_W-1:0];
          end else if (reg_hit(addr, base, `SUB_COMPARE)) begin
            compare_buffer_q <= wr_data[CNT_W-1:0];
          end
        end
      end

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          internal_down_counter_q <= `RST_16;
          compare_latch_q         <= `RST_16;
          hold_cnt_q              <= `RST_16;
          hold_cmp_q              <= `RST_16;
          hold_valid_q            <= 1'b0;
          zero_q                  <= 1'b0;
        end else begin
          zero_q <= reach_zero;
          if (manual) begin
            internal_down_counter_q <= count_reload_buffer_q;
            compare_latch_q         <= compare_buffer_q;
            hold_valid_q            <= 1'b0;
          end else if (start & tick) begin
            if (internal_down_counter_q != 16'h0000) begin
              internal_down_counter_q <= internal_down_counter_q - 16'h0001;
              if (reach_zero & auto) begin
                hold_cnt_q   <= count_reload_buffer_q;
                hold_cmp_q   <= compare_buffer_q;
                hold_valid_q <= 1'b1;
              end
            end else if (auto) begin
              // reload tick is the period's last one
              internal_down_counter_q <= hold_valid_q ? hold_cnt_q
                                                      : count_reload_buffer_q;
              compare_latch_q <= hold_valid_q ? hold_cmp_q : compare_buffer_q;
              hold_valid_q    <= 1'b0;
            end
            // zero without auto-reload: counter stays at zero
          end
        end
      end

      assign reload_all[g*CNT_W +: CNT_W]  = count_reload_buffer_q;
      assign compare_all[g*CNT_W +: CNT_W] = compare_buffer_q;
      assign counter_all[g*CNT_W +: CNT_W] = internal_down_counter_q;
      assign level_all[g] = (internal_down_counter_q <= compare_latch_q) ^ invert;
      assign zero_all[g]  = zero_q;
      assign tick_all[g]  = tick;
    end
  endgenerate

  // ----------------------------------------------------------------
  // dead zone for timer 0 pair
  // ----------------------------------------------------------------
  // both outputs stay low for dz_len timer 0 ticks after each edge
  reg       dz_prev_q;
  reg [7:0] dz_cnt_q;
  wire      dz_done = (dz_cnt_q == 8'h00);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dz_prev_q <= 1'b0;
      dz_cnt_q  <= 8'h00;
    end else begin
      dz_prev_q <= level_all[0];
      if (level_all[0] != dz_prev_q) begin
        dz_cnt_q <= dz_len;
      end else if (tick_all[0] && !dz_done) begin
        dz_cnt_q <= dz_cnt_q - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // output pins and interrupt pulses
  // ----------------------------------------------------------------
  // pulses only, no sticky status: a request that software misses is lost
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_output_pin <= 4'h0;
      irq_pulse        <= 5'h00;
    end else begin
      timer_output_pin[0] <= dz_en ? (level_all[0] & dz_done & (level_all[0] == dz_prev_q))
                                   : level_all[0];
      timer_output_pin[1] <= dz_en ? (~level_all[0] & dz_done & (level_all[0] == dz_prev_q))
                                   : level_all[1];
      timer_output_pin[3:2] <= level_all[3:2];
      irq_pulse <= zero_all & irq_enable_q;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // observation offsets have no write decode, so writes there are dropped
  reg  [31:0]        rd_d;
  wire [`ADDR_W-1:0] toff = addr - `A_TIMER_BASE;
  wire [2:0]         tidx = toff[6:4];

  always @* begin
    rd_d = `RST_32;
    if (addr == `A_PRESCALER) begin
      rd_d = {8'h00, prescaler_config_q};
    end else if (addr == `A_DIVSEL) begin
      rd_d = {12'h000, divider_select_config_q};
    end else if (addr == `A_CONTROL) begin
      rd_d = {11'h000, timer_control_bits_q};
    end else if (addr == `A_IRQ_EN) begin
      rd_d = {27'h0000000, irq_enable_q};
    end else if (addr >= `A_TIMER_BASE && addr <= `A_TIMER_LAST) begin
      if (toff[3:0] == `SUB_RELOAD) begin
        rd_d = {16'h0000, reload_all[tidx*CNT_W +: CNT_W]};
      end else if (toff[3:0] == `SUB_COMPARE) begin
        rd_d = {16'h0000, compare_all[tidx*CNT_W +: CNT_W]};
      end else if (toff[3:0] == `SUB_OBSERVE) begin
        rd_d = {16'h0000, counter_all[tidx*CNT_W +: CNT_W]};
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= `RST_32;
    end else begin
      rd_data <= rd_stb ? rd_d : `RST_32;
    end
  end

endmodule // five_channel_pwm_timer

`default_nettype wire

/* File: verilog/pwm_timer_defines.vh */
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W            8
`define A_PRESCALER       8'h00
`define A_DIVSEL          8'h04
`define A_CONTROL         8'h08
`define A_IRQ_EN          8'h0C
`define A_TIMER_BASE      8'h10
`define A_TIMER_LAST      8'h5F
`define TIMER_IDX_LSB     4
`define SUB_RELOAD        4'h0
`define SUB_COMPARE       4'h4
`define SUB_OBSERVE       4'h8

// ----------------------------------------------------------------
// prescaler_config fields
// ----------------------------------------------------------------
`define PRE0_LSB          0
`define PRE1_LSB          8
`define DZLEN_LSB         16
`define PRE_W             8

// ----------------------------------------------------------------
// timer_control_bits fields: four bits per timer, then dead zone
// ----------------------------------------------------------------
`define CTL_STRIDE        4
`define CTL_START         0
`define CTL_MANUAL        1
`define CTL_INVERT        2
`define CTL_AUTO          3
`define CTL_DZ_EN         20
`define CTL_W             21

// ----------------------------------------------------------------
// divider_select_config: four bits per timer
// ----------------------------------------------------------------
`define DIV_STRIDE        4
`define DIV_W             20
`define SEL_DIV2          4'h0
`define SEL_DIV4          4'h1
`define SEL_DIV8          4'h2
`define SEL_DIV16         4'h3
`define SEL_EXT           4'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_16            16'h0000
`define RST_32            32'h00000000

`endif
